// ### shared/bsr_map.svh
// register offsets, field layout, reset values and voltage figures of the buck set-point bank
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH

`define BSR_ADDR_NORMAL    8'h35
`define BSR_ADDR_STANDBY   8'h36
`define BSR_ADDR_SLEEP     8'h37

`define BSR_CODE_MSB       5
`define BSR_CODE_LSB       0
`define BSR_RANGE_BIT      6
`define BSR_UNUSED_BIT     7

`define BSR_CODE_RESET     6'h00
`define BSR_RANGE_RESET    1'b0
`define BSR_RDATA_RESET    8'h00

`define BSR_LOW_BASE_MV    12'h190
`define BSR_LOW_STEP_MV    12'h019
`define BSR_HIGH_BASE_MV   12'h320
`define BSR_HIGH_STEP_MV   12'h032
`define BSR_HIGH_MAX_MV    12'hce4
`define BSR_FLOOR_MV       12'h258

`endif

// ### shared/bsr_pkg.sv
// types shared by the buck set-point bank
package bsr_pkg;

   typedef enum logic [1:0] {
      BSR_MODE_NORMAL  = 2'b00,
      BSR_MODE_STANDBY = 2'b01,
      BSR_MODE_SLEEP   = 2'b10
   } bsr_mode_t;

   typedef enum logic {
      BSR_ST_LOAD = 1'b0,
      BSR_ST_RUN  = 1'b1
   } bsr_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bsr_reg_req_t;

   typedef struct packed {
      logic [6:0]  code;
      logic [11:0] mv;
      logic        unsupported;
   } bsr_vout_t;

endpackage : bsr_pkg

// ### src/bsr_code_to_mv.sv
// converts a 7-bit range/set-point code to millivolts and flags unusable codes
`timescale 1ns/10ps
`include "bsr_map.svh"

module bsr_code_to_mv (
   // code in
   input  wire logic [6:0]  code_i,
   // result out
   output logic      [11:0] mv_o,
   output logic             unsupported_o
);

   logic [11:0] steps;

   always_comb begin
      steps = {6'h00, code_i[`BSR_CODE_MSB:`BSR_CODE_LSB]};
      if (code_i[`BSR_RANGE_BIT]) begin
         mv_o = 12'(`BSR_HIGH_BASE_MV + steps * `BSR_HIGH_STEP_MV);
      end else begin
         mv_o = 12'(`BSR_LOW_BASE_MV + steps * `BSR_LOW_STEP_MV);
      end
      // at or below the floor, or above the high-range top
      unsupported_o = (mv_o <= `BSR_FLOOR_MV) || (mv_o > `BSR_HIGH_MAX_MV);
   end

endmodule : bsr_code_to_mv

// ### src/bsr_setpoint_regs.sv
// set-point register bank of the second buck regulator
`timescale 1ns/10ps
`include "bsr_map.svh"

module bsr_setpoint_regs #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic                 MCLK_I,
   input  wire logic                 RSTN_I,
   input  wire logic                 CE_I,
   // one-time settings
   input  wire logic                 OTP_VALID_I,
   input  wire logic                 OTP_RANGE_I,
   // register access from the serial engine
   input  wire bsr_pkg::bsr_reg_req_t REG_REQ_I,
   output logic       [7:0]          REG_RDATA_O,
   output logic                      REG_ACK_O,
   // operating mode and regulator drive
   input  wire bsr_pkg::bsr_mode_t   MODE_I,
   output bsr_pkg::bsr_vout_t        VOUT_O,
   output logic                      READY_O
);

   bsr_pkg::bsr_state_t state;
   logic [5:0]  normal_setpoint_code;
   logic [5:0]  standby_setpoint_code;
   logic [5:0]  sleep_setpoint_code;
   logic        range_select_bit;
   logic        standby_range_copy;
   logic        sleep_range_copy;
   logic [6:0]  next_code;
   logic [11:0] conv_mv;
   logic        conv_unsupported;
   logic        wr_ok;
   logic [2:0]  wr_sel;
   logic        loaded_range;

   // the register port decodes exactly eight address bits
   if (ADDR_W != 8) begin : g_addr_w_check
      $error("bsr_setpoint_regs: register address must be 8 bits");
   end

   // range bit must sit just above the set-point field
   if (`BSR_RANGE_BIT != `BSR_CODE_MSB + 1) begin : g_layout_check
      $error("bsr_setpoint_regs: range bit must follow the set-point field");
   end

   // set-point field must be six bits wide
   if (`BSR_CODE_MSB - `BSR_CODE_LSB != 5) begin : g_field_check
      $error("bsr_setpoint_regs: set-point field must be six bits");
   end

   // range on top of the 6-bit field
   function automatic logic [6:0] build_code(input logic range, input logic [5:0] code);
      build_code = {range, code};
   endfunction : build_code

   // one-hot write select: bit 0 normal, bit 1 standby, bit 2 sleep
   function automatic logic [2:0] write_select(input logic [7:0] addr);
      if (addr == `BSR_ADDR_NORMAL) begin
         write_select = 3'b001;
      end else if (addr == `BSR_ADDR_STANDBY) begin
         write_select = 3'b010;
      end else if (addr == `BSR_ADDR_SLEEP) begin
         write_select = 3'b100;
      end else begin
         write_select = 3'b000;
      end
   endfunction : write_select

   // unmapped addresses read as zero
   function automatic logic [7:0] read_word(input logic [7:0] addr,
                                            input logic       rn, input logic [5:0] cn,
                                            input logic       rs, input logic [5:0] cs,
                                            input logic       rz, input logic [5:0] cz);
      if (addr == `BSR_ADDR_NORMAL) begin
         read_word = {1'b0, build_code(rn, cn)};
      end else if (addr == `BSR_ADDR_STANDBY) begin
         read_word = {1'b0, build_code(rs, cs)};
      end else if (addr == `BSR_ADDR_SLEEP) begin
         read_word = {1'b0, build_code(rz, cz)};
      end else begin
         read_word = `BSR_RDATA_RESET;
      end
   endfunction : read_word

   // without a one-time setting the range falls back to its default
   function automatic logic range_source(input logic valid, input logic range);
      range_source = valid ? range : `BSR_RANGE_RESET;
   endfunction : range_source

   assign loaded_range = range_source(OTP_VALID_I, OTP_RANGE_I);

   // range is loaded once after reset, then frozen
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state <= bsr_pkg::BSR_ST_LOAD;
      end else if (CE_I) begin
         case (state)
            bsr_pkg::BSR_ST_LOAD: state <= bsr_pkg::BSR_ST_RUN;
            bsr_pkg::BSR_ST_RUN:  state <= bsr_pkg::BSR_ST_RUN;
            default:              state <= bsr_pkg::BSR_ST_LOAD;
         endcase
      end
   end

   // no host write path reaches the range bit
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         range_select_bit <= `BSR_RANGE_RESET;
      end else if (CE_I && state == bsr_pkg::BSR_ST_LOAD) begin
         range_select_bit <= loaded_range;
      end
   end

   // standby and sleep inherit the same initial range
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         standby_range_copy <= `BSR_RANGE_RESET;
         sleep_range_copy   <= `BSR_RANGE_RESET;
      end else if (CE_I && state == bsr_pkg::BSR_ST_LOAD) begin
         standby_range_copy <= loaded_range;
         sleep_range_copy   <= loaded_range;
      end
   end

   // host writes only once the range is settled
   assign wr_ok  = CE_I && REG_REQ_I.wr && state == bsr_pkg::BSR_ST_RUN;
   assign wr_sel = wr_ok ? write_select(REG_REQ_I.addr) : 3'b000;

   // bits 7:6 of a write are dropped
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         normal_setpoint_code <= `BSR_CODE_RESET;
      end else if (wr_sel[0]) begin
         normal_setpoint_code <= REG_REQ_I.wdata[`BSR_CODE_MSB:`BSR_CODE_LSB];
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         standby_setpoint_code <= `BSR_CODE_RESET;
      end else if (wr_sel[1]) begin
         standby_setpoint_code <= REG_REQ_I.wdata[`BSR_CODE_MSB:`BSR_CODE_LSB];
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sleep_setpoint_code <= `BSR_CODE_RESET;
      end else if (wr_sel[2]) begin
         sleep_setpoint_code <= REG_REQ_I.wdata[`BSR_CODE_MSB:`BSR_CODE_LSB];
      end
   end

   // every taken request is acknowledged, refused writes too
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         REG_ACK_O <= 1'b0;
      end else if (CE_I) begin
         REG_ACK_O <= REG_REQ_I.wr || REG_REQ_I.rd;
      end
   end

   // read data shows the value before a same-cycle write
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         REG_RDATA_O <= `BSR_RDATA_RESET;
      end else if (CE_I && REG_REQ_I.rd) begin
         REG_RDATA_O <= read_word(REG_REQ_I.addr,
                                  range_select_bit, normal_setpoint_code,
                                  standby_range_copy, standby_setpoint_code,
                                  sleep_range_copy, sleep_setpoint_code);
      end
   end

   // active-mode code selection
   always_comb begin
      case (MODE_I)
         bsr_pkg::BSR_MODE_NORMAL:  next_code = build_code(range_select_bit, normal_setpoint_code);
         bsr_pkg::BSR_MODE_STANDBY: next_code = build_code(standby_range_copy, standby_setpoint_code);
         bsr_pkg::BSR_MODE_SLEEP:   next_code = build_code(sleep_range_copy, sleep_setpoint_code);
         // the unused mode code falls back to normal
         default:                   next_code = build_code(range_select_bit, normal_setpoint_code);
      endcase
   end

   bsr_code_to_mv u_conv (
      .code_i        (next_code),
      .mv_o          (conv_mv),
      .unsupported_o (conv_unsupported)
   );

   // regulator drive, one cycle behind mode and codes
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         VOUT_O <= '0;
      end else if (CE_I) begin
         VOUT_O.code        <= next_code;
         VOUT_O.mv          <= conv_mv;
         VOUT_O.unsupported <= conv_unsupported;
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         READY_O <= 1'b0;
      end else if (CE_I) begin
         READY_O <= state == bsr_pkg::BSR_ST_RUN;
      end
   end

endmodule : bsr_setpoint_regs

// ### verification/bsr_host.sv
// host model issuing single-byte register transfers
`timescale 1ns/10ps
module bsr_host (
   // clock
   input  wire logic             clk_i,
   // answer from the bank
   input  wire logic             ack_i,
   input  wire logic [7:0]       rdata_i,
   // request to the bank
   output bsr_pkg::bsr_reg_req_t req_o
);
   initial req_o = '0;
   // codes at or below the floor are sent only when a scenario asks
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q, output logic k);
      @(posedge clk_i);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '0;
      @(negedge clk_i);
      q = rdata_i;
      k = ack_i;
   endtask : xfer
endmodule : bsr_host

// ### verification/bsr_setpoint_asserts.sv
// port-level assertions for the buck set-point bank
`timescale 1ns/10ps
module bsr_setpoint_asserts (
   // clock, reset, settings
   input wire logic                  MCLK_I,
   input wire logic                  RSTN_I,
   input wire logic                  CE_I,
   input wire logic                  OTP_VALID_I,
   input wire logic                  OTP_RANGE_I,
   // register port
   input wire bsr_pkg::bsr_reg_req_t REG_REQ_I,
   input wire logic [7:0]            REG_RDATA_O,
   input wire logic                  REG_ACK_O,
   // mode and regulator drive
   input wire bsr_pkg::bsr_mode_t    MODE_I,
   input wire bsr_pkg::bsr_vout_t    VOUT_O,
   input wire logic                  READY_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   wire logic [11:0] c = {6'h00, VOUT_O.code[5:0]};
   sequence s_take; CE_I && (REG_REQ_I.wr || REG_REQ_I.rd); endsequence
   sequence s_run; READY_O && $past(READY_O, 2); endsequence
   sequence s_wr_norm; CE_I && READY_O && REG_REQ_I.wr && REG_REQ_I.addr == 8'h35; endsequence
   sequence s_hold_norm; CE_I && MODE_I == bsr_pkg::BSR_MODE_NORMAL && !REG_REQ_I.wr; endsequence
   AST_ACK: assert property (s_take |=> REG_ACK_O) else $error("no ack after request");
   AST_NOACK: assert property (CE_I && !REG_REQ_I.wr && !REG_REQ_I.rd |=> !REG_ACK_O)
      else $error("ack without request");
   AST_RANGE_FIXED: assert property (s_run |-> $stable(VOUT_O.code[6])) else $error("range moved");
   AST_LOW_MAP: assert property (s_run and !VOUT_O.code[6] |-> VOUT_O.mv == 12'h190 + 12'h019 * c)
      else $error("low range value wrong");
   AST_HIGH_MAP: assert property (s_run and VOUT_O.code[6] |-> VOUT_O.mv == 12'h320 + 12'h032 * c)
      else $error("high range value wrong");
   AST_FLAG: assert property (s_run |-> VOUT_O.unsupported == (VOUT_O.mv <= 12'h258 || VOUT_O.mv > 12'hce4))
      else $error("unsupported flag wrong");
   AST_NORMAL_PATH: assert property (s_wr_norm ##1 s_hold_norm |=> c[5:0] == $past(REG_REQ_I.wdata[5:0], 2))
      else $error("normal code not driven");
   AST_READBACK: assert property (s_run and REG_ACK_O && $past(CE_I && REG_REQ_I.rd) |->
      !REG_RDATA_O[7] && (REG_RDATA_O == 8'h00 || REG_RDATA_O[6] == VOUT_O.code[6])) else $error("range copy wrong");
endmodule : bsr_setpoint_asserts
bind bsr_setpoint_regs bsr_setpoint_asserts u_chk (.MCLK_I, .RSTN_I, .CE_I, .OTP_VALID_I, .OTP_RANGE_I,
   .REG_REQ_I, .REG_RDATA_O, .REG_ACK_O, .MODE_I, .VOUT_O, .READY_O);

// ### verification/bsr_setpoint_regs_tb.sv
// self-checking bench for the buck set-point bank
`timescale 1ns/10ps
module bsr_setpoint_regs_tb;
   logic                  mclk, rstn, ce, otp_v, otp_r, ack, rdy, k;
   logic [7:0]            rdata, q;
   bsr_pkg::bsr_reg_req_t req;
   bsr_pkg::bsr_mode_t    mode;
   bsr_pkg::bsr_vout_t    vout;
   int                    errors, compares;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   bsr_setpoint_regs DUT (.MCLK_I(mclk), .RSTN_I(rstn), .CE_I(ce), .OTP_VALID_I(otp_v), .OTP_RANGE_I(otp_r),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_ACK_O(ack), .MODE_I(mode), .VOUT_O(vout), .READY_O(rdy));
   bsr_host host (.clk_i(mclk), .ack_i(ack), .rdata_i(rdata), .req_o(req));
   task check(input logic [19:0] seen, input logic [19:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task do_reset(input logic v, input logic r);
      int n;
      @(posedge mclk);
      rstn <= 1'b0;
      otp_v <= v;
      otp_r <= r;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      for (n = 0; n < 8 && rdy !== 1'b1; n++) @(negedge mclk);
      if (rdy !== 1'b1) begin
         errors++;
         complete_run();
      end
   endtask : do_reset
   task wr(input logic [7:0] a, d);
      host.xfer(1'b1, a, d, q, k);
      check({19'h0, k}, 20'h1);
   endtask : wr
   task rd(input logic [7:0] a, exp);
      host.xfer(1'b0, a, 8'h00, q, k);
      check({11'h0, k, q}, {11'h0, 1'b1, exp});
   endtask : rd
   task vchk(input bsr_pkg::bsr_mode_t m, input logic [6:0] c, input logic [11:0] mv, input logic u);
      @(posedge mclk);
      mode <= m;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(vout, {c, mv, u});
   endtask : vchk
   task sc_high_range;
      do_reset(1'b1, 1'b1);
      wr(8'h35, 8'h2a);
      vchk(bsr_pkg::BSR_MODE_NORMAL, 7'h6a, 12'hb54, 1'b0);
      wr(8'h36, 8'hff);
      vchk(bsr_pkg::BSR_MODE_STANDBY, 7'h7f, 12'hf6e, 1'b1);
      wr(8'h37, 8'h05);
      vchk(bsr_pkg::BSR_MODE_SLEEP, 7'h45, 12'h41a, 1'b0);
      wr(8'h35, 8'h15);
      rd(8'h35, 8'h55);
      rd(8'h36, 8'h7f);
      rd(8'h37, 8'h45);
      rd(8'h38, 8'h00);
   endtask : sc_high_range
   task sc_low_range;
      do_reset(1'b0, 1'b1);
      rd(8'h37, 8'h00);
      wr(8'h35, 8'h08);
      vchk(bsr_pkg::BSR_MODE_NORMAL, 7'h08, 12'h258, 1'b1);
      wr(8'h35, 8'h09);
      vchk(bsr_pkg::BSR_MODE_NORMAL, 7'h09, 12'h271, 1'b0);
      wr(8'h36, 8'h3f);
      vchk(bsr_pkg::BSR_MODE_STANDBY, 7'h3f, 12'h7b7, 1'b0);
   endtask : sc_low_range
   task sc_freeze;
      @(posedge mclk);
      ce <= 1'b0;
      mode <= bsr_pkg::BSR_MODE_NORMAL;
      host.xfer(1'b1, 8'h35, 8'h3c, q, k);
      check({19'h0, k}, 20'h0);
      check(vout, {7'h3f, 12'h7b7, 1'b0});
      @(posedge mclk);
      ce <= 1'b1;
      rd(8'h35, 8'h09);
      vchk(bsr_pkg::bsr_mode_t'(2'b11), 7'h09, 12'h271, 1'b0);
   endtask : sc_freeze
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      otp_v = 1'b0;
      otp_r = 1'b0;
      mode = bsr_pkg::BSR_MODE_NORMAL;
      errors = 0;
      compares = 0;
      sc_high_range();
      sc_low_range();
      sc_freeze();
      complete_run();
   end
endmodule : bsr_setpoint_regs_tb
